//--- design/txm_defines.svh
// shared constants of the transmit modulator and power mode block
`ifndef TXM_DEFINES_SVH
`define TXM_DEFINES_SVH
// ************************************************
// timing
// ************************************************
`define TXM_CLK_NS 20
`define TXM_SLEEP_EXIT_NS 10000
`define TXM_STBY_EXIT_NS 1000
`define TXM_CHIP_CLKS 4
// ************************************************
// packet layout and spreading
// ************************************************
`define TXM_PRE_BITS 9'h080
`define TXM_HDR_BITS 9'h030
`define TXM_SIG_BITS 8'h08
`define TXM_BARKER 11'h5b8
`define TXM_BARKER_LAST 4'ha
`define TXM_CCK_LAST 4'h7
`define TXM_SCR_SEED 7'h6c
`define TXM_SIG_1M 8'h0a
`define TXM_SIG_2M 8'h14
`define TXM_SIG_5M5 8'h37
`define TXM_SIG_11M 8'h6e
// ************************************************
// dac levels and observation fields
// ************************************************
`define TXM_DAC_POS 6'h1f
`define TXM_DAC_NEG 6'h21
`define TXM_DAC_OBS_EN 0
`define TXM_DAC_OBS_SRC 1
`define TXM_OBS_PWR 3'h0
`define TXM_OBS_SEQ 3'h1
`define TXM_OBS_DAC_I 3'h2
`define TXM_OBS_DAC_Q 3'h3
`define TXM_OBS_AGC 3'h4
`define TXM_OBS_NF 3'h5
`define TXM_OBS_RXRATE 3'h6
`endif

//--- design/txm_pkg.sv
// types of the transmit modulator and power mode block
package txm_pkg;
	typedef enum logic [1:0] {rate_1m = 2'h0, rate_2m = 2'h1, rate_5m5 = 2'h2, rate_11m = 2'h3} txm_rate_t;
	typedef enum logic [2:0] {pwr_sleep = 3'h0, pwr_standby = 3'h1, pwr_tx = 3'h2, pwr_rx = 3'h3,
		pwr_duplex = 3'h4} txm_pwr_t;
	typedef enum logic [1:0] {seq_idle = 2'h0, seq_pre = 2'h1, seq_hdr = 2'h2, seq_data = 2'h3} txm_seq_t;
endpackage

//--- design/txm_power.sv
// power state decode and receiver/transmitter wake timing
`timescale 1ns/1ps
`include "txm_defines.svh"
module txm_power #(
	parameter int CW = 10
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// power pins
	input  wire logic        rx_power_enable,
	input  wire logic        tx_power_enable,
	input  wire logic        dev_reset,
	// status
	output txm_pkg::txm_pwr_t pwr_state_q,
	output logic             rx_ready_q,
	output logic             tx_ready_q
);
	localparam logic [CW-1:0] SLEEP_CLKS = CW'(`TXM_SLEEP_EXIT_NS / `TXM_CLK_NS);
	localparam logic [CW-1:0] STBY_CLKS  = CW'(`TXM_STBY_EXIT_NS / `TXM_CLK_NS);

	txm_pkg::txm_pwr_t pwr_state_d;
	logic [CW-1:0]     cnt_q;
	logic [CW-1:0]     cnt_d;
	logic              asleep_q;
	logic              asleep_d;
	logic              rx_ready_d;
	logic              tx_ready_d;

	always_comb begin
		if (!rx_power_enable && !tx_power_enable) begin
			pwr_state_d = dev_reset ? txm_pkg::pwr_sleep : txm_pkg::pwr_standby; // see [R24] see [R10]
		end else if (!rx_power_enable) begin
			pwr_state_d = txm_pkg::pwr_tx;
		end else if (!tx_power_enable) begin
			pwr_state_d = txm_pkg::pwr_rx;
		end else begin
			pwr_state_d = txm_pkg::pwr_duplex;
		end
		asleep_d = asleep_q;
		if (dev_reset) begin
			asleep_d = 1'b1; // see [R07]
		end else if (rx_ready_q) begin
			asleep_d = 1'b0;
		end
		cnt_d = cnt_q;
		rx_ready_d = rx_ready_q;
		if (!rx_power_enable || dev_reset) begin
			cnt_d = '0; // see [R05] see [R07]
			rx_ready_d = 1'b0;
		end else if (!rx_ready_q) begin
			cnt_d = cnt_q + 1'b1;
			if (cnt_d >= (asleep_q ? SLEEP_CLKS : STBY_CLKS)) begin
				rx_ready_d = 1'b1; // see [R11] see [R12] see [R10]
			end
		end
		tx_ready_d = tx_power_enable; // see [R06] see [R13]
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pwr_state_q <= txm_pkg::pwr_standby;
			cnt_q <= '0;
			asleep_q <= 1'b1;
			rx_ready_q <= 1'b0;
			tx_ready_q <= 1'b0;
		end else begin
			pwr_state_q <= pwr_state_d;
			cnt_q <= cnt_d;
			asleep_q <= asleep_d;
			rx_ready_q <= rx_ready_d;
			tx_ready_q <= tx_ready_d;
		end
	end

	// ************************************************
	// checks
	// ************************************************
	sequence s_sleep_exit;
		dev_reset ##1 (!dev_reset && rx_power_enable);
	endsequence
	property p_rx_off;
		@(posedge clk) disable iff (rst) !rx_power_enable |=> !rx_ready_q;
	endproperty
	a_rx_off: assert property (p_rx_off) else $error("receiver enabled without power enable"); // see [R05]
	property p_tx_off;
		@(posedge clk) disable iff (rst) !tx_power_enable |=> !tx_ready_q;
	endproperty
	a_tx_off: assert property (p_tx_off) else $error("transmitter enabled without power enable"); // see [R06]
	property p_rx_fast;
		@(posedge clk) disable iff (rst) (!asleep_q && !dev_reset && $rose(rx_power_enable))
			|-> ##[1:50] (rx_ready_q || !rx_power_enable || dev_reset);
	endproperty
	a_rx_fast: assert property (p_rx_fast) else $error("receiver late from standby"); // see [R11] see [R12]
	property p_rx_sleep_exit;
		@(posedge clk) disable iff (rst) s_sleep_exit |-> ##[1:500] (rx_ready_q || !rx_power_enable || dev_reset);
	endproperty
	a_rx_sleep_exit: assert property (p_rx_sleep_exit) else $error("receiver late from sleep"); // see [R07]
	property p_tx_wake;
		@(posedge clk) disable iff (rst) $rose(tx_power_enable) ##1 tx_power_enable |-> tx_ready_q;
	endproperty
	a_tx_wake: assert property (p_tx_wake) else $error("transmitter wake over two clocks"); // see [R13]
	property p_sleep_state;
		@(posedge clk) disable iff (rst) (dev_reset && !rx_power_enable && !tx_power_enable)
			|=> pwr_state_q == txm_pkg::pwr_sleep && !rx_ready_q && !tx_ready_q;
	endproperty
	a_sleep_state: assert property (p_sleep_state) else $error("sleep state not entered"); // see [R10]
endmodule

//--- design/txm_chip.sv
// chip phase generator for barker and complementary code spreading
`timescale 1ns/1ps
`include "txm_defines.svh"
module txm_chip (
	// symbol
	input  wire logic       cck,
	input  wire logic       rate_11m,
	input  wire logic [3:0] chip_idx,
	input  wire logic [5:0] sel,
	input  wire logic [1:0] phase,
	// chip
	output logic      [1:0] chip_phase
);
	localparam logic [10:0] BARKER = `TXM_BARKER;

	logic [1:0] p2;
	logic [1:0] p3;
	logic [1:0] p4;
	logic [1:0] s;

	always_comb begin
		p2 = rate_11m ? sel[1:0] : {sel[0], 1'b1}; // see [R18] see [R19]
		p3 = rate_11m ? sel[3:2] : 2'h0;
		p4 = rate_11m ? sel[5:4] : {sel[1], 1'b0};
		case (chip_idx[2:0])
			3'h0: s = p2 + p3 + p4;
			3'h1: s = p3 + p4;
			3'h2: s = p2 + p4;
			3'h3: s = p4 + 2'h2;
			3'h4: s = p2 + p3;
			3'h5: s = p3;
			3'h6: s = p2 + 2'h2;
			default: s = 2'h0;
		endcase
		if (!cck) begin
			s = BARKER[4'(`TXM_BARKER_LAST - chip_idx)] ? 2'h0 : 2'h2; // see [R17]
		end
		chip_phase = phase + s;
	end
endmodule

//--- design/txm_top.sv
// transmit modulator, power mode control, rf gain step and observation port
// How it works
// [R01] IF at half supply: pad and gain together
// [R02] observation pins show selected internal signal
// [R03] readback register mirrors observation pins
// [R04] DACs may show receiver signals instead
// [R05] receiver off while receive enable low
// [R06] transmitter off while transmit enable low
// [R07] reset sleeps receiver; wake within 10us
// [R08] power modes never touch configuration
// [R09] reset keeps AGC and noise floor values
// [R10] sleep: all off, registers kept, 10us
// [R11] standby wakes within 1us of enable
// [R12] receiver joins transmit within 1us
// [R13] transmitter joins receive within 2 clocks
// [R14] DBPSK 1M, DQPSK 2M, CCK 5.5/11M
// [R15] rate codes 00..11 map four rates
// [R16] preamble DBPSK, header per setup, switch
// [R17] low rates scramble, differential, barker spread
// [R18] 5.5M: nibble picks code and phase
// [R19] 11M: byte picks code and phase
// [R20] header last phase starts data phase
// [R21] modulator independent of demodulator
// [R22] controller holds enable low to restart
// [R23] setup low bits choose data modulation
// [R24] power state decoded from pin levels
`timescale 1ns/1ps
`include "txm_defines.svh"
module txm_top #(
	parameter int CHIP_CLKS = `TXM_CHIP_CLKS
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// power pins
	input  wire logic              rx_power_enable,
	input  wire logic              tx_power_enable,
	input  wire logic              dev_reset,
	// configuration
	input  wire logic [1:0]        tx_rate_setup_reg,
	input  wire logic              header_dqpsk,
	input  wire logic [1:0]        rx_signal_rate_reg,
	input  wire logic [2:0]        observation_select_reg,
	input  wire logic [1:0]        dac_observation_reg,
	// transmit data
	input  wire logic              tx_data,
	output logic                   tx_bit_take_q,
	// receiver side
	input  wire logic              if_level_high,
	input  wire logic              agc_update,
	input  wire logic [6:0]        agc_gain_in,
	input  wire logic [6:0]        noise_floor_in,
	input  wire logic [5:0]        rx_probe_i,
	input  wire logic [5:0]        rx_probe_q,
	// status and analog controls
	output txm_pkg::txm_pwr_t      pwr_state_q,
	output logic                   rx_enabled_q,
	output logic                   tx_enabled_q,
	output txm_pkg::txm_rate_t     rx_rate_kind_q,
	output logic                   rf_pad_q,
	output logic                   if_gain_boost_q,
	output logic [5:0]             tx_dac_i_q,
	output logic [5:0]             tx_dac_q_q,
	// observation
	output logic [7:0]             observation_pins_q,
	output logic [7:0]             observation_readback_reg_q
);
	localparam int DW = $clog2(CHIP_CLKS);
	localparam logic [DW-1:0] DIV_LAST = DW'(CHIP_CLKS - 1);

	txm_pkg::txm_seq_t  seq_q, seq_d, fld;
	txm_pkg::txm_rate_t rx_rate_kind_d;
	logic [7:0]    cnt_q, cnt_d, base, raw, sb, gath_q, gath_d, sig, hidx;
	logic [8:0]    sum;
	logic [3:0]    n_q, n_d, n_nx, n_data, chip_q, chip_d, gcnt_q, gcnt_d, last;
	logic [DW-1:0] div_q, div_d;
	logic [6:0]    scr_q, scr_d, agc_q, agc_d, nf_q, nf_d;
	logic [5:0]    sel_q, sel_d, dac_i_d, dac_q_d;
	logic [1:0]    phase_q, phase_d, dib, chip_phase;
	logic [7:0]    obs_d;
	logic          cck_q, cck_d, r11_q, r11_d, take_d, sym_end, load, nd, rf_pad_d;

	txm_power i_txm_power (
		.clk             (clk),
		.rst             (rst),
		.rx_power_enable (rx_power_enable),
		.tx_power_enable (tx_power_enable),
		.dev_reset       (dev_reset),
		.pwr_state_q     (pwr_state_q),
		.rx_ready_q      (rx_enabled_q),
		.tx_ready_q      (tx_enabled_q)
	);

	txm_chip i_txm_chip (
		.cck        (cck_q),
		.rate_11m   (r11_q),
		.chip_idx   (chip_q),
		.sel        (sel_q),
		.phase      (phase_q),
		.chip_phase (chip_phase)
	);

	// ************************************************
	// modulator sequencing
	// ************************************************
	always_comb begin
		seq_d = seq_q; cnt_d = cnt_q; n_d = n_q; chip_d = chip_q; div_d = div_q;
		cck_d = cck_q; r11_d = r11_q; phase_d = phase_q; scr_d = scr_q; sel_d = sel_q;
		gath_d = gath_q; gcnt_d = gcnt_q; take_d = 1'b0;
		fld = seq_q; base = 8'h00; raw = 8'h00; sb = 8'h00; sum = 9'h000; n_nx = 4'h1; dib = 2'h0; hidx = 8'h00;
		case (tx_rate_setup_reg) // see [R23] see [R15] see [R08]
			2'h0: begin n_data = 4'h1; sig = `TXM_SIG_1M; end
			2'h1: begin n_data = 4'h2; sig = `TXM_SIG_2M; end
			2'h2: begin n_data = 4'h4; sig = `TXM_SIG_5M5; end
			default: begin n_data = 4'h8; sig = `TXM_SIG_11M; end
		endcase
		last = cck_q ? `TXM_CCK_LAST : `TXM_BARKER_LAST;
		sym_end = seq_q != txm_pkg::seq_idle && chip_q == last && div_q == DIV_LAST;
		load = sym_end || (seq_q == txm_pkg::seq_idle && tx_enabled_q);
		nd = seq_q == txm_pkg::seq_data || (seq_q == txm_pkg::seq_hdr && {1'b0, cnt_q} + 9'(n_q) >= `TXM_HDR_BITS);
		div_d = div_q + 1'b1;
		if (div_q == DIV_LAST) begin
			div_d = '0;
			chip_d = chip_q + 1'b1;
		end
		if (nd && !load && !tx_bit_take_q && gcnt_q < n_data) begin
			gath_d[gcnt_q[2:0]] = tx_data;
			gcnt_d = gcnt_q + 1'b1;
			take_d = 1'b1;
		end
		if (load) begin
			sum = {1'b0, cnt_q} + 9'(n_q);
			if (seq_q == txm_pkg::seq_idle) begin
				fld = txm_pkg::seq_pre;
			end else if (seq_q == txm_pkg::seq_pre && sum >= `TXM_PRE_BITS) begin
				fld = txm_pkg::seq_hdr; // see [R16]
			end else if (seq_q == txm_pkg::seq_hdr && sum >= `TXM_HDR_BITS) begin
				fld = txm_pkg::seq_data;
			end else if (seq_q != txm_pkg::seq_data) begin
				base = sum[7:0];
			end
			case (fld)
				txm_pkg::seq_pre: n_nx = 4'h1; // see [R16]
				txm_pkg::seq_hdr: n_nx = header_dqpsk ? 4'h2 : 4'h1;
				default: n_nx = n_data;
			endcase
			for (int i = 0; i < 8; i++) begin
				hidx = base + 8'(i);
				if (fld == txm_pkg::seq_pre) begin
					raw[i] = 1'b1;
				end else if (fld == txm_pkg::seq_hdr) begin
					raw[i] = hidx < `TXM_SIG_BITS ? sig[hidx[2:0]] : 1'b0;
				end else begin
					raw[i] = gath_q[i];
				end
				if (4'(i) < n_nx) begin
					sb[i] = raw[i] ^ scr_d[6] ^ scr_d[3]; // see [R17]
					scr_d = {scr_d[5:0], sb[i]};
				end
			end
			dib = {sb[0], sb[0] ^ sb[1]};
			cck_d = 1'b0;
			r11_d = 1'b0;
			if (fld == txm_pkg::seq_data && tx_rate_setup_reg[1]) begin
				phase_d = phase_q + dib; // see [R18] see [R19] see [R14] see [R20]
				sel_d = sb[7:2];
				cck_d = 1'b1;
				r11_d = tx_rate_setup_reg[0];
			end else if (n_nx == 4'h2) begin
				phase_d = phase_q + dib; // see [R17] see [R14]
			end else begin
				phase_d = phase_q + {sb[0], 1'b0};
			end
			seq_d = fld;
			cnt_d = base;
			n_d = n_nx;
			chip_d = 4'h0;
			div_d = '0;
			gcnt_d = 4'h0;
		end
		if (!tx_enabled_q) begin
			seq_d = txm_pkg::seq_idle; // see [R06] see [R22]
			scr_d = `TXM_SCR_SEED;
			phase_d = 2'h0;
			chip_d = 4'h0;
			div_d = '0;
			gcnt_d = 4'h0;
			take_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			seq_q <= txm_pkg::seq_idle; cnt_q <= 8'h00; n_q <= 4'h1; chip_q <= 4'h0; div_q <= '0;
			cck_q <= 1'b0; r11_q <= 1'b0; phase_q <= 2'h0; scr_q <= `TXM_SCR_SEED; sel_q <= 6'h00;
			gath_q <= 8'h00; gcnt_q <= 4'h0; tx_bit_take_q <= 1'b0;
		end else begin
			seq_q <= seq_d; cnt_q <= cnt_d; n_q <= n_d; chip_q <= chip_d; div_q <= div_d;
			cck_q <= cck_d; r11_q <= r11_d; phase_q <= phase_d; scr_q <= scr_d; sel_q <= sel_d;
			gath_q <= gath_d; gcnt_q <= gcnt_d; tx_bit_take_q <= take_d;
		end
	end

	// ************************************************
	// dac, gain step, agc memory, observation
	// ************************************************
	always_comb begin
		rf_pad_d = rx_enabled_q && if_level_high; // see [R01]
		agc_d = agc_q;
		nf_d = nf_q;
		if (rx_enabled_q && agc_update && !dev_reset) begin
			agc_d = agc_gain_in; // see [R09]
			nf_d = noise_floor_in;
		end
		rx_rate_kind_d = txm_pkg::txm_rate_t'(rx_signal_rate_reg); // see [R15]
		if (dac_observation_reg[`TXM_DAC_OBS_EN]) begin
			dac_i_d = dac_observation_reg[`TXM_DAC_OBS_SRC] ? agc_q[6:1] : rx_probe_i; // see [R04]
			dac_q_d = dac_observation_reg[`TXM_DAC_OBS_SRC] ? nf_q[6:1] : rx_probe_q;
		end else if (tx_enabled_q && seq_q != txm_pkg::seq_idle) begin
			dac_i_d = (chip_phase[1] ^ chip_phase[0]) ? `TXM_DAC_NEG : `TXM_DAC_POS; // see [R21]
			dac_q_d = chip_phase[1] ? `TXM_DAC_NEG : `TXM_DAC_POS;
		end else begin
			dac_i_d = 6'h00;
			dac_q_d = 6'h00;
		end
		case (observation_select_reg) // see [R02]
			`TXM_OBS_PWR: obs_d = {5'h00, pwr_state_q};
			`TXM_OBS_SEQ: obs_d = {seq_q, cck_q, phase_q, rf_pad_q, rx_enabled_q, tx_enabled_q};
			`TXM_OBS_DAC_I: obs_d = {2'h0, tx_dac_i_q};
			`TXM_OBS_DAC_Q: obs_d = {2'h0, tx_dac_q_q};
			`TXM_OBS_AGC: obs_d = {1'b0, agc_q};
			`TXM_OBS_NF: obs_d = {1'b0, nf_q};
			`TXM_OBS_RXRATE: obs_d = {6'h00, rx_rate_kind_q};
			default: obs_d = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rf_pad_q <= 1'b0; if_gain_boost_q <= 1'b0; agc_q <= 7'h00; nf_q <= 7'h00;
			rx_rate_kind_q <= txm_pkg::rate_1m; tx_dac_i_q <= 6'h00; tx_dac_q_q <= 6'h00;
			observation_pins_q <= 8'h00; observation_readback_reg_q <= 8'h00;
		end else begin
			rf_pad_q <= rf_pad_d;
			if_gain_boost_q <= rf_pad_d; // see [R01]
			agc_q <= agc_d; nf_q <= nf_d; rx_rate_kind_q <= rx_rate_kind_d;
			tx_dac_i_q <= dac_i_d; tx_dac_q_q <= dac_q_d;
			observation_pins_q <= obs_d;
			observation_readback_reg_q <= obs_d; // see [R03]
		end
	end

	// ************************************************
	// checks
	// ************************************************
	sequence s_pre_to_hdr;
		seq_q == txm_pkg::seq_pre ##1 seq_q == txm_pkg::seq_hdr;
	endsequence
	property p_rf_step;
		@(posedge clk) disable iff (rst) (rx_enabled_q && if_level_high) |=> (rf_pad_q && if_gain_boost_q);
	endproperty
	a_rf_step: assert property (p_rf_step) else $error("pad and gain step not together"); // see [R01]
	property p_obs_pwr;
		@(posedge clk) disable iff (rst) observation_select_reg == `TXM_OBS_PWR
			|=> observation_pins_q == {5'h00, $past(pwr_state_q)};
	endproperty
	a_obs_pwr: assert property (p_obs_pwr) else $error("observation pins wrong"); // see [R02]
	property p_readback;
		@(posedge clk) disable iff (rst) observation_readback_reg_q == observation_pins_q;
	endproperty
	a_readback: assert property (p_readback) else $error("readback differs from pins"); // see [R03]
	property p_dac_obs;
		@(posedge clk) disable iff (rst) dac_observation_reg == 2'h1 |=> tx_dac_i_q == $past(rx_probe_i);
	endproperty
	a_dac_obs: assert property (p_dac_obs) else $error("dac observation not shown"); // see [R04]
	property p_agc_keep;
		@(posedge clk) disable iff (rst) dev_reset ##1 dev_reset |-> $stable(agc_q) && $stable(nf_q);
	endproperty
	a_agc_keep: assert property (p_agc_keep) else $error("agc values lost in reset"); // see [R09]
	property p_hdr_mod;
		@(posedge clk) disable iff (rst) s_pre_to_hdr |-> !cck_q && (n_q == 4'h1 || n_q == 4'h2);
	endproperty
	a_hdr_mod: assert property (p_hdr_mod) else $error("header modulation wrong"); // see [R16]
	property p_data_mod;
		@(posedge clk) disable iff (rst) (seq_q == txm_pkg::seq_data && $stable(tx_rate_setup_reg))
			|-> cck_q == tx_rate_setup_reg[1];
	endproperty
	a_data_mod: assert property (p_data_mod) else $error("data modulation wrong for rate"); // see [R14]
	property p_tx_quiet;
		@(posedge clk) disable iff (rst) (!tx_enabled_q && !dac_observation_reg[0]) |=> tx_dac_i_q == 6'h00;
	endproperty
	a_tx_quiet: assert property (p_tx_quiet) else $error("dac driven while disabled"); // see [R06]
	property p_rx_rate;
		@(posedge clk) disable iff (rst) ##1 rx_rate_kind_q == $past(rx_signal_rate_reg);
	endproperty
	a_rx_rate: assert property (p_rx_rate) else $error("rx rate code wrong"); // see [R15]
endmodule

//--- sim/txm_mac_model.sv
// packet controller model driving the transmit enable and serial transmit data
`timescale 1ns/1ps
module txm_mac_model #(
	parameter int GAP = 212
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// bench request
	input  wire logic tx_go,
	// device side
	input  wire logic tx_bit_take_q,
	output logic      tx_power_enable,
	output logic      tx_data
);
	int         gap_cnt;
	logic [2:0] pat_q;
	// ****************************************
	// enable and data, changed at the falling edge
	// ****************************************
	always @(negedge clk) begin
		if (rst) begin
			tx_power_enable <= 1'b0;
			tx_data <= 1'b0;
			pat_q <= 3'h0;
			gap_cnt <= GAP;
		end else if (!tx_go) begin
			tx_power_enable <= 1'b0;
			gap_cnt <= (gap_cnt < GAP) ? gap_cnt + 1 : GAP;
		end else if (gap_cnt >= GAP) begin
			tx_power_enable <= 1'b1;
			gap_cnt <= 0;
		end
		if (tx_bit_take_q && !rst) begin
			pat_q <= pat_q + 3'h1;
			tx_data <= pat_q[0] ^ pat_q[2];
		end
	end
endmodule

//--- sim/txm_top_tb.sv
// self-checking bench of the transmit modulator and power mode block
`timescale 1ns/1ps
module txm_top_tb;
	logic clk, rst, rx_power_enable, tx_power_enable, dev_reset, tx_go, header_dqpsk;
	logic [1:0] tx_rate_setup_reg, rx_signal_rate_reg, dac_observation_reg;
	logic [2:0] observation_select_reg;
	logic tx_data, tx_bit_take_q, if_level_high, agc_update;
	logic [6:0] agc_gain_in, noise_floor_in;
	logic [5:0] rx_probe_i, rx_probe_q, tx_dac_i_q, tx_dac_q_q;
	txm_pkg::txm_pwr_t pwr_state_q;
	txm_pkg::txm_rate_t rx_rate_kind_q;
	logic rx_enabled_q, tx_enabled_q, rf_pad_q, if_gain_boost_q;
	logic [7:0] observation_pins_q, observation_readback_reg_q;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	txm_top i_txm_top (.clk(clk), .rst(rst), .rx_power_enable(rx_power_enable),
		.tx_power_enable(tx_power_enable), .dev_reset(dev_reset), .tx_rate_setup_reg(tx_rate_setup_reg),
		.header_dqpsk(header_dqpsk), .rx_signal_rate_reg(rx_signal_rate_reg),
		.observation_select_reg(observation_select_reg), .dac_observation_reg(dac_observation_reg),
		.tx_data(tx_data), .tx_bit_take_q(tx_bit_take_q), .if_level_high(if_level_high),
		.agc_update(agc_update), .agc_gain_in(agc_gain_in), .noise_floor_in(noise_floor_in),
		.rx_probe_i(rx_probe_i), .rx_probe_q(rx_probe_q), .pwr_state_q(pwr_state_q),
		.rx_enabled_q(rx_enabled_q), .tx_enabled_q(tx_enabled_q), .rx_rate_kind_q(rx_rate_kind_q),
		.rf_pad_q(rf_pad_q), .if_gain_boost_q(if_gain_boost_q), .tx_dac_i_q(tx_dac_i_q),
		.tx_dac_q_q(tx_dac_q_q), .observation_pins_q(observation_pins_q),
		.observation_readback_reg_q(observation_readback_reg_q));
	txm_mac_model i_txm_mac_model (.clk(clk), .rst(rst), .tx_go(tx_go), .tx_bit_take_q(tx_bit_take_q),
		.tx_power_enable(tx_power_enable), .tx_data(tx_data));
	// ****************************************
	// clock, timeout and reporting
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			num_errors++;
			stop_test();
		end
	end
	task automatic stop_test();
		if (num_errors == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic check_range(input int got, input int lo, input int hi);
		comparisons++;
		if (got < lo || got > hi) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h..%h", $time, got, lo, hi);
		end
	endtask
	task automatic wait_rx(input int lim);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (rx_enabled_q !== 1'b1 && n < 600);
		check_range(n, 1, lim);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_power();
		check_val({5'h0, pwr_state_q}, 8'h01);
		check_val({7'h0, rx_enabled_q}, 8'h00);
		dev_reset <= 1'b1;
		repeat (3) @(negedge clk);
		check_val({5'h0, pwr_state_q}, 8'h00);
		check_val({6'h0, rx_enabled_q, tx_enabled_q}, 8'h00);
		dev_reset <= 1'b0;
		rx_power_enable <= 1'b1;
		wait_rx(500);
		check_val({5'h0, pwr_state_q}, 8'h03);
		rx_power_enable <= 1'b0;
		repeat (2) @(negedge clk);
		check_val({4'h0, pwr_state_q, rx_enabled_q}, 8'h02);
		rx_power_enable <= 1'b1;
		wait_rx(50);
	endtask
	task automatic t_agc_obs();
		if_level_high <= 1'b1;
		repeat (2) @(negedge clk);
		check_val({6'h0, rf_pad_q, if_gain_boost_q}, 8'h03);
		if_level_high <= 1'b0;
		agc_gain_in <= 7'h55;
		noise_floor_in <= 7'h33;
		agc_update <= 1'b1;
		@(negedge clk);
		agc_update <= 1'b0;
		observation_select_reg <= 3'h4;
		repeat (3) @(negedge clk);
		check_val(observation_pins_q, 8'h55);
		check_val(observation_readback_reg_q, 8'h55);
		observation_select_reg <= 3'h1;
		repeat (3) @(negedge clk);
		check_val(observation_pins_q, 8'h02);
		observation_select_reg <= 3'h4;
		dev_reset <= 1'b1;
		repeat (3) @(negedge clk);
		dev_reset <= 1'b0;
		wait_rx(500);
		check_val(observation_pins_q, 8'h55);
		observation_select_reg <= 3'h5;
		repeat (3) @(negedge clk);
		check_val(observation_readback_reg_q, 8'h33);
		observation_select_reg <= 3'h7;
		repeat (3) @(negedge clk);
		check_val(observation_pins_q, 8'h00);
		dac_observation_reg <= 2'b01;
		rx_probe_i <= 6'h2a;
		rx_probe_q <= 6'h15;
		observation_select_reg <= 3'h2;
		repeat (3) @(negedge clk);
		check_val({tx_dac_i_q, 2'h0} | {6'h0, tx_dac_q_q[5:4]}, 8'ha9);
		check_val({2'h0, tx_dac_q_q}, 8'h15);
		check_val(observation_pins_q, 8'h2a);
		observation_select_reg <= 3'h3;
		dac_observation_reg <= 2'b11;
		repeat (3) @(negedge clk);
		check_val({2'h0, tx_dac_q_q}, 8'h19);
		check_val(observation_pins_q, 8'h19);
		dac_observation_reg <= 2'b00;
	endtask
	task automatic t_rates();
		observation_select_reg <= 3'h6;
		for (int c = 0; c < 4; c++) begin
			rx_signal_rate_reg <= 2'(c);
			repeat (2) @(negedge clk);
			check_val({6'h0, rx_rate_kind_q}, 8'(c));
			check_val(observation_pins_q, 8'(c));
		end
		observation_select_reg <= 3'h0;
	endtask
	task automatic t_tx(input int r);
		int n, bad, takes, sym, bps;
		sym = (r < 2) ? 44 : 32;
		bps = 1 << r;
		tx_rate_setup_reg <= 2'(r);
		tx_go <= 1'b1;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (tx_enabled_q !== 1'b1 && n < 20);
		check_range(n, 1, 3);
		bad = 0;
		takes = 0;
		repeat (100 * 44) begin
			@(negedge clk);
			bad += (tx_dac_i_q !== tx_dac_q_q);
			takes += (tx_bit_take_q === 1'b1);
		end
		check_range(bad + takes, 0, 0);
		check_val({5'h0, pwr_state_q}, 8'h04);
		n = 0;
		while (tx_bit_take_q !== 1'b1 && n < 80 * 44) begin
			@(negedge clk);
			n++;
		end
		check_range(n, 74 * 44, 77 * 44);
		repeat (2 * sym) @(negedge clk);
		bad = 0;
		takes = 0;
		repeat (10 * sym) begin
			@(negedge clk);
			bad += (tx_dac_i_q !== tx_dac_q_q);
			takes += (tx_bit_take_q === 1'b1);
		end
		check_range(takes, 9 * bps, 11 * bps);
		if (r == 0) begin
			check_range(bad, 0, 0);
			rx_power_enable <= 1'b0;
			repeat (2) @(negedge clk);
			check_val({5'h0, pwr_state_q}, 8'h02);
			rx_power_enable <= 1'b1;
			wait_rx(50);
		end
		tx_go <= 1'b0;
		repeat (3) @(negedge clk);
		check_val({1'b0, tx_enabled_q, tx_dac_i_q}, 8'h00);
		repeat (220) @(negedge clk);
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rst = 1'b1;
		rx_power_enable = 1'b0;
		dev_reset = 1'b0;
		tx_go = 1'b0;
		header_dqpsk = 1'b0;
		tx_rate_setup_reg = 2'h0;
		rx_signal_rate_reg = 2'h0;
		dac_observation_reg = 2'h0;
		observation_select_reg = 3'h0;
		if_level_high = 1'b0;
		agc_update = 1'b0;
		agc_gain_in = 7'h00;
		noise_floor_in = 7'h00;
		rx_probe_i = 6'h00;
		rx_probe_q = 6'h00;
		repeat (16) @(negedge clk);
		rst <= 1'b0;
		@(negedge clk);
		t_power();
		t_agc_obs();
		t_rates();
		for (int r = 0; r < 4; r++) t_tx(r);
		stop_test();
	end
endmodule
